// *** dv/sleep_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sleep_cpu_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic go,
  input wire logic wk,
  input wire logic irq_dispatch,
  input wire logic reset_vector_start,
  output logic power_halt_op,
  output logic watchdog_irq
);
  // The halt instruction is one cycle wide and follows each go pulse of the bench, whether the arm bit was written or not.
  always_ff @(posedge clk) begin
    if (!reset_n) power_halt_op <= 1'b0;
    else power_halt_op <= go;
  end

  // The waking level stays up until the core is released, else the interrupt is lost.
  always_ff @(posedge clk) begin
    if (!reset_n) watchdog_irq <= 1'b0;
    else if (wk) watchdog_irq <= 1'b1;
    else if (irq_dispatch || reset_vector_start) watchdog_irq <= 1'b0;
  end
endmodule
`default_nettype wire

// *** dv/sleep_mode_controller_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_controller_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic any_reset,
  input wire logic converter_enabled,
  input wire logic core_clock_en,
  input wire logic flash_clock_en,
  input wire logic io_clock_en,
  input wire logic converter_clock_en,
  input wire logic async_clock_en,
  input wire logic main_osc_en,
  input wire logic brownout_detector_en,
  input wire logic start_conversion,
  input wire logic core_halt,
  input wire logic irq_dispatch,
  input wire logic reset_vector_start
);
  logic arm_q;
  logic [2:0] mode_q;

  // ****************************************************************
  // Shadow of the sleep control register, taken from completed writes.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      arm_q <= 1'b0;
      mode_q <= 3'h0;
    end else if (psel && penable && pwrite && pready &&
                 paddr == sleep_pkg::sleep_control_addr) begin
      arm_q <= pwdata[sleep_pkg::sleep_arm_bit];
      mode_q <= pwdata[sleep_pkg::sleep_select_lsb +: 3];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ****************************************************************
  // Properties.
  // ****************************************************************
  a_halt_needs_arm: assert property ($rose(core_halt) |-> arm_q)
    else $error("halted without the arm bit");
  a_core_clock_runs: assert property (!core_halt && !$past(core_halt) && !$past(core_halt, 2)
    |-> core_clock_en && flash_clock_en)
    else $error("core clock stopped while running");
  a_idle_keeps_io: assert property (core_halt && mode_q == 3'h0
    |-> io_clock_en && converter_clock_en && async_clock_en)
    else $error("idle stopped a peripheral clock");
  a_io_stop_mode: assert property ($fell(io_clock_en) |-> mode_q != 3'h0)
    else $error("io clock stopped in idle");
  a_osc_stop_mode: assert property ($fell(main_osc_en)
    |-> !(mode_q inside {3'h0, 3'h1, 3'h6, 3'h7}))
    else $error("oscillator stopped in a mode that keeps it");
  a_halt_four: assert property (irq_dispatch |-> $past(core_halt) &&
    $past(core_halt, 2) && $past(core_halt, 3) && $past(core_halt, 4))
    else $error("interrupt dispatched without four halt cycles");
  a_bod_sleep_only: assert property ($fell(brownout_detector_en) |-> core_halt)
    else $error("detector switched off while running");
  a_bod_back_on: assert property (irq_dispatch |-> brownout_detector_en)
    else $error("code resumed with detector off");
  a_reset_vector: assert property (reset_vector_start |-> $past(any_reset))
    else $error("reset vector start without reset");
  a_conv_on_entry: assert property (start_conversion
    |-> converter_enabled && mode_q < 3'h2)
    else $error("conversion started in a wrong mode");
  a_reset_releases: assert property (reset_vector_start
    |-> !core_halt && !irq_dispatch)
    else $error("reset vector start while halted or dispatching");
endmodule

bind sleep_mode_controller sleep_mode_controller_asserts sleep_mode_controller_asserts_inst (
  .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .any_reset,
  .converter_enabled, .core_clock_en, .flash_clock_en, .io_clock_en, .converter_clock_en,
  .async_clock_en, .main_osc_en, .brownout_detector_en, .start_conversion, .core_halt,
  .irq_dispatch, .reset_vector_start);
`default_nettype wire

// *** dv/sleep_mode_controller_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
`define WAITON(c) begin n = 0; while (!(c) && n < 4000) begin @(negedge clk); n++; end \
  if (n >= 4000) begin bad_count++; give_verdict(); end end
module sleep_mode_controller_test;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, err, go, wk, conv_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic power_halt_op, any_reset, crystal_selected, global_irq_enable, timer2_enabled;
  logic timer2_async, timer2_sync, pin_change_irq, two_wire_match, watchdog_irq;
  logic conversion_done, store_ready_irq, serial_start_frame, other_io_irq, converter_enabled;
  logic [3:0] clock_select_fuse;
  logic [1:0] timer2_irq_mask, timer2_events, ext_irq_pins, ext_irq_level_mode;
  logic core_clock_en, flash_clock_en, io_clock_en, converter_clock_en, async_clock_en;
  logic main_osc_en, timer_osc_en, brownout_detector_en, start_conversion, core_halt;
  logic irq_dispatch, reset_vector_start;
  int bad_count, check_count, n;
  typedef struct packed {logic [2:0] m; logic [5:0] e; logic [3:0] w;} row_t;
  // Mode, expected {core, flash, io, converter, async, oscillator} and the wake source used.
  row_t rows [6] = '{'{3'h0, 6'h0F, 4'h2}, '{3'h1, 6'h07, 4'h2}, '{3'h2, 6'h00, 4'h8},
    '{3'h3, 6'h00, 4'h4}, '{3'h6, 6'h01, 4'h1}, '{3'h7, 6'h01, 4'h8}};

  sleep_mode_controller sleep_mode_controller_inst (.clk, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .power_halt_op, .any_reset, .clock_select_fuse,
    .crystal_selected, .global_irq_enable, .timer2_irq_mask, .timer2_events, .timer2_enabled,
    .timer2_async, .timer2_sync, .ext_irq_pins, .ext_irq_level_mode, .pin_change_irq,
    .two_wire_match, .watchdog_irq, .conversion_done, .store_ready_irq, .serial_start_frame,
    .other_io_irq, .converter_enabled, .core_clock_en, .flash_clock_en, .io_clock_en,
    .converter_clock_en, .async_clock_en, .main_osc_en, .timer_osc_en, .brownout_detector_en,
    .start_conversion, .core_halt, .irq_dispatch, .reset_vector_start);
  sleep_cpu_model sleep_cpu_model_inst (.clk, .reset_n, .go, .wk, .irq_dispatch,
    .reset_vector_start, .power_halt_op, .watchdog_irq);

  // Free-running clock and a sticky flag for the one-cycle conversion pulse.
  always #20 clk = ~clk;
  // The flag is cleared by the halt request, so one process owns it.
  always @(negedge clk) begin
    if (go === 1'b1) conv_seen = 1'b0;
    else if (start_conversion === 1'b1) conv_seen = 1'b1;
  end

  // ****************************************************************
  // Tasks.
  // ****************************************************************
  task automatic give_verdict();
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never drives psel twice in one step.
    @(posedge clk);
  endtask

  // Arms a mode, lets the core issue the halt and waits until the clocks have settled.
  task automatic sleep_in(input logic [2:0] m);
    apb(1'b1, sleep_pkg::sleep_control_addr, {28'h0, m, 1'b1});
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    `WAITON(core_halt === 1'b1)
    repeat (4) @(posedge clk);
  endtask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    {clk, reset_n, psel, penable, pwrite, paddr, pwdata, go, wk, any_reset, timer2_enabled,
      timer2_async, timer2_sync, pin_change_irq, two_wire_match, conversion_done, store_ready_irq,
      serial_start_frame, other_io_irq, clock_select_fuse, timer2_irq_mask, timer2_events,
      ext_irq_pins, ext_irq_level_mode} = '0;
    {crystal_selected, global_irq_enable, converter_enabled} = 3'h7;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    `CHK({core_clock_en, main_osc_en, brownout_detector_en, core_halt}, 4'hE,
      "reset outputs")
    apb(1'b0, sleep_pkg::mcu_control_addr, 32'h0);
    `CHK(rd, 32'h0, "control reset value")
    apb(1'b0, 8'h10, 32'h0);
    `CHK(err, 1'b1, "unmapped address accepted")
    foreach (rows[i]) begin
      sleep_in(rows[i].m);
      `CHK({core_clock_en, flash_clock_en, io_clock_en, converter_clock_en, async_clock_en,
        main_osc_en}, rows[i].e, "clock gating")
      `CHK(conv_seen, rows[i].m < 3'h2, "conversion on entry")
      `CHK(brownout_detector_en, 1'b1, "detector dropped")
      {pin_change_irq, two_wire_match, store_ready_irq, serial_start_frame} <= rows[i].w;
      `WAITON(irq_dispatch === 1'b1)
      @(posedge clk);
      {pin_change_irq, two_wire_match, store_ready_irq, serial_start_frame} <= 4'h0;
      repeat (2) @(posedge clk);
      `CHK({core_halt, core_clock_en}, 2'h1, "not resumed")
    end
    apb(1'b1, sleep_pkg::sleep_control_addr, 32'h4);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK(core_halt, 1'b0, "slept unarmed")
    sleep_in(3'h1);
    other_io_irq <= 1'b1;
    repeat (30) @(posedge clk);
    `CHK(core_halt, 1'b1, "woke on other io")
    conversion_done <= 1'b1;
    `WAITON(irq_dispatch === 1'b1)
    @(posedge clk);
    {other_io_irq, conversion_done} <= 2'h0;
    sleep_in(3'h2);
    ext_irq_pins <= 2'h1;
    repeat (30) @(posedge clk);
    `CHK(core_halt, 1'b1, "woke on edge pin")
    ext_irq_level_mode <= 2'h1;
    `WAITON(irq_dispatch === 1'b1)
    @(posedge clk);
    ext_irq_pins <= 2'h0;
    timer2_enabled <= 1'b1;
    timer2_irq_mask <= 2'h2;
    sleep_in(3'h3);
    `CHK(timer_osc_en, 1'b0, "timer oscillator left on")
    timer2_events <= 2'h2;
    `WAITON(irq_dispatch === 1'b1)
    @(posedge clk);
    timer2_events <= 2'h0;
    sleep_in(3'h2);
    apb(1'b0, sleep_pkg::status_addr, 32'h0);
    `CHK(rd, {27'h0, 1'b0, sleep_pkg::mode_power_down, 1'b1}, "status asleep")
    any_reset <= 1'b1;
    `WAITON(reset_vector_start === 1'b1)
    @(posedge clk);
    any_reset <= 1'b0;
    apb(1'b1, sleep_pkg::mcu_control_addr, 32'h20);
    apb(1'b1, sleep_pkg::mcu_control_addr, 32'h40);
    apb(1'b0, sleep_pkg::mcu_control_addr, 32'h0);
    `CHK(rd[6], 1'b1, "timed write lost")
    sleep_in(3'h2);
    `CHK(brownout_detector_en, 1'b0, "detector kept on")
    apb(1'b0, sleep_pkg::status_addr, 32'h0);
    `CHK(rd, {27'h0, 1'b1, sleep_pkg::mode_power_down, 1'b1}, "status detector")
    wk <= 1'b1;
    @(posedge clk);
    wk <= 1'b0;
    `WAITON(irq_dispatch === 1'b1)
    `CHK(n >= 1500, 1'b1, "wake too short")
    `CHK(brownout_detector_en, 1'b1, "detector not back")
    // A second reset in mid-run clears the sleep-off bit, and a lone write stays refused.
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, sleep_pkg::mcu_control_addr, 32'h0);
    `CHK(rd, 32'h0, "control not cleared by reset")
    apb(1'b1, sleep_pkg::mcu_control_addr, 32'h40);
    apb(1'b0, sleep_pkg::mcu_control_addr, 32'h0);
    `CHK(rd, 32'h0, "untimed write accepted")
    give_verdict();
  end
endmodule
`default_nettype wire

// *** verilog/sleep_mode_controller.sv ***
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_controller (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_halt_op,
  input wire logic any_reset,
  input wire logic [3:0] clock_select_fuse,
  input wire logic crystal_selected,
  input wire logic global_irq_enable,
  input wire logic [1:0] timer2_irq_mask,
  input wire logic [1:0] timer2_events,
  input wire logic timer2_enabled,
  input wire logic timer2_async,
  input wire logic timer2_sync,
  input wire logic [1:0] ext_irq_pins,
  input wire logic [1:0] ext_irq_level_mode,
  input wire logic pin_change_irq,
  input wire logic two_wire_match,
  input wire logic watchdog_irq,
  input wire logic conversion_done,
  input wire logic store_ready_irq,
  input wire logic serial_start_frame,
  input wire logic other_io_irq,
  input wire logic converter_enabled,
  output logic core_clock_en,
  output logic flash_clock_en,
  output logic io_clock_en,
  output logic converter_clock_en,
  output logic async_clock_en,
  output logic main_osc_en,
  output logic timer_osc_en,
  output logic brownout_detector_en,
  output logic start_conversion,
  output logic core_halt,
  output logic irq_dispatch,
  output logic reset_vector_start
);

  // ****************************************************************
  // Registers and state.
  // ****************************************************************
  logic [2:0] sleep_select;
  logic sleep_arm;
  logic brownout_sleep_off;
  logic [2:0] seq_count;
  logic [2:0] mode;
  logic bod_was_off;
  logic woke_by_reset;
  logic [15:0] wait_count;
  sleep_pkg::state_t state;
  logic wr;
  logic wake;
  logic enter;

  // Start-up delay from the clock fuse; sixteen cycles per fuse step plus sixteen, computed in logic.
  function automatic logic [15:0] startup_cycles(input logic [3:0] sel);
    return {8'h00, sel, 4'h0} + 16'h0010;
  endfunction

  // Deep modes are those where the detector may be turned off.
  function automatic logic deep_mode(input logic [2:0] m);
    return (m == sleep_pkg::mode_power_down) || (m == sleep_pkg::mode_power_save) ||
           (m == sleep_pkg::mode_standby) || (m == sleep_pkg::mode_ext_standby);
  endfunction

  // ****************************************************************
  // APB slave: zero wait states, unmapped reads give zero and error.
  // ****************************************************************
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;

  always_comb begin
    pslverr = psel && penable && (paddr != sleep_pkg::sleep_control_addr) &&
              (paddr != sleep_pkg::mcu_control_addr) && (paddr != sleep_pkg::status_addr);
  end

  // Read data is registered in the setup cycle so it stands in the access phase.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        sleep_pkg::sleep_control_addr: prdata <= {28'h0000000, sleep_select, sleep_arm};
        sleep_pkg::mcu_control_addr: prdata <= {25'h0000000, brownout_sleep_off,
                                                (seq_count != 3'h0), 5'h00};
        sleep_pkg::status_addr: prdata <= {27'h0000000, bod_was_off, mode, 1'b0} |
                                          {31'h00000000, state != sleep_pkg::st_run};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // Sleep control register; only the CPU writes it, hardware never clears it.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sleep_arm <= sleep_pkg::sleep_control_reset[sleep_pkg::sleep_arm_bit];
      sleep_select <= sleep_pkg::sleep_control_reset[sleep_pkg::sleep_select_lsb +: 3];
    end else if (wr && paddr == sleep_pkg::sleep_control_addr) begin
      sleep_arm <= pwdata[sleep_pkg::sleep_arm_bit];
      sleep_select <= pwdata[sleep_pkg::sleep_select_lsb +: 3];
    end
  end

  // Timed sequence: enable bit opens a four-cycle window for the sleep-off bit.
  // Rewriting the enable inside the window does not extend it.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      seq_count <= 3'h0;
      brownout_sleep_off <= sleep_pkg::mcu_control_reset[sleep_pkg::brownout_sleep_off_bit];
    end else if (wr && paddr == sleep_pkg::mcu_control_addr &&
                 pwdata[sleep_pkg::sleep_off_enable_bit] && seq_count == 3'h0) begin
      seq_count <= 3'(sleep_pkg::seq_window_cycles);
    end else if (wr && paddr == sleep_pkg::mcu_control_addr && seq_count != 3'h0) begin
      brownout_sleep_off <= pwdata[sleep_pkg::brownout_sleep_off_bit];
      seq_count <= 3'h0;
    end else if (seq_count != 3'h0) begin
      seq_count <= seq_count - 3'h1;
    end
  end

  // ****************************************************************
  // Wake source selection per mode.
  // ****************************************************************
  always_comb begin
    logic lvl;
    logic t2;
    lvl = |(ext_irq_pins & ext_irq_level_mode);
    t2 = timer2_enabled && global_irq_enable && |(timer2_events & timer2_irq_mask);
    unique case (mode)
      sleep_pkg::mode_idle: wake = |ext_irq_pins || pin_change_irq || two_wire_match ||
                                   watchdog_irq || conversion_done || store_ready_irq ||
                                   serial_start_frame || other_io_irq || t2;
      sleep_pkg::mode_noise: wake = conversion_done || watchdog_irq || two_wire_match ||
                                    (t2 && timer2_async) || store_ready_irq || lvl ||
                                    pin_change_irq || serial_start_frame;
      sleep_pkg::mode_power_save,
      sleep_pkg::mode_ext_standby: wake = watchdog_irq || two_wire_match || lvl ||
                                          pin_change_irq || serial_start_frame || t2;
      default: wake = watchdog_irq || two_wire_match || lvl || pin_change_irq ||
                      serial_start_frame;
    endcase
  end

  // Entry needs the armed bit and the halt instruction together.
  assign enter = sleep_arm && power_halt_op;

  // ****************************************************************
  // Sequencer.
  // ****************************************************************
  // Reset while not running wins over every wake step and starts at the reset vector; memory is never touched.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= sleep_pkg::st_run;
      mode <= sleep_pkg::mode_idle;
      bod_was_off <= 1'b0;
      woke_by_reset <= 1'b0;
      wait_count <= 16'h0000;
    end else if (any_reset && state != sleep_pkg::st_run) begin
      state <= sleep_pkg::st_run;
      woke_by_reset <= 1'b1;
      bod_was_off <= 1'b0;
    end else begin
      woke_by_reset <= 1'b0;
      unique case (state)
        sleep_pkg::st_run: begin
          if (enter) begin
            state <= sleep_pkg::st_sleep;
            mode <= sleep_select;
            bod_was_off <= brownout_sleep_off && deep_mode(sleep_select);
          end
        end
        sleep_pkg::st_sleep: begin
          if (wake) begin
            state <= sleep_pkg::st_startup;
            if (bod_was_off) begin
              wait_count <= 16'(sleep_pkg::brownout_wake_cycles);
            end else if (mode == sleep_pkg::mode_standby ||
                         mode == sleep_pkg::mode_ext_standby) begin
              wait_count <= 16'(sleep_pkg::standby_wake_cycles);
            end else if (mode == sleep_pkg::mode_idle || mode == sleep_pkg::mode_noise) begin
              wait_count <= 16'h0001;
            end else begin
              wait_count <= startup_cycles(clock_select_fuse);
            end
          end
        end
        sleep_pkg::st_startup: begin
          if (wait_count <= 16'h0001) begin
            state <= sleep_pkg::st_halt;
            wait_count <= 16'(sleep_pkg::halt_cycles);
          end else begin
            wait_count <= wait_count - 16'h0001;
          end
        end
        sleep_pkg::st_halt: begin
          if (wait_count <= 16'h0001) begin
            state <= sleep_pkg::st_run;
            bod_was_off <= 1'b0;
          end else begin
            wait_count <= wait_count - 16'h0001;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Clock gating and outputs, registered so they are glitch free.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      core_clock_en <= 1'b1;
      flash_clock_en <= 1'b1;
      io_clock_en <= 1'b1;
      converter_clock_en <= 1'b1;
      async_clock_en <= 1'b1;
      main_osc_en <= 1'b1;
      timer_osc_en <= 1'b1;
      brownout_detector_en <= 1'b1;
    end else if (state == sleep_pkg::st_sleep) begin
      core_clock_en <= 1'b0;
      flash_clock_en <= 1'b0;
      io_clock_en <= (mode == sleep_pkg::mode_idle);
      converter_clock_en <= (mode == sleep_pkg::mode_idle) || (mode == sleep_pkg::mode_noise);
      async_clock_en <= (mode == sleep_pkg::mode_idle) || (mode == sleep_pkg::mode_noise) ||
                        (((mode == sleep_pkg::mode_power_save) ||
                          (mode == sleep_pkg::mode_ext_standby)) && timer2_async);
      main_osc_en <= (mode == sleep_pkg::mode_idle) || (mode == sleep_pkg::mode_noise) ||
                     (mode == sleep_pkg::mode_standby) || (mode == sleep_pkg::mode_ext_standby) ||
                     (mode == sleep_pkg::mode_power_save && timer2_sync);
      // The timer oscillator runs only for an asynchronous timer 2, and only in modes
      // that keep it; Power-down stops it with every other source, and Standby stops it but keeps the main oscillator.
      timer_osc_en <= timer2_async && ((mode == sleep_pkg::mode_idle) ||
                      (mode == sleep_pkg::mode_noise) || (mode == sleep_pkg::mode_power_save) ||
                      (mode == sleep_pkg::mode_ext_standby));
      brownout_detector_en <= !bod_was_off;
    end else begin
      core_clock_en <= 1'b1;
      flash_clock_en <= 1'b1;
      io_clock_en <= 1'b1;
      converter_clock_en <= 1'b1;
      async_clock_en <= 1'b1;
      main_osc_en <= 1'b1;
      timer_osc_en <= 1'b1;
      brownout_detector_en <= 1'b1;
    end
  end

  // Conversion start on entry, halt indication and dispatch pulses.
  // No path writes register file or SRAM here; memory is simply left alone.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      start_conversion <= 1'b0;
      core_halt <= 1'b0;
      irq_dispatch <= 1'b0;
      reset_vector_start <= 1'b0;
    end else begin
      start_conversion <= (state == sleep_pkg::st_run) && enter && converter_enabled &&
                          ((sleep_select == sleep_pkg::mode_idle) ||
                           (sleep_select == sleep_pkg::mode_noise));
      core_halt <= enter || (state != sleep_pkg::st_run && !(any_reset));
      irq_dispatch <= (state == sleep_pkg::st_halt) && (wait_count <= 16'h0001) && !any_reset;
      reset_vector_start <= (any_reset && state != sleep_pkg::st_run);
    end
  end

endmodule
`default_nettype wire

// *** verilog/sleep_pkg.sv ***
package sleep_pkg;

  // ****************************************************************
  // Register map, byte addresses on the bus.
  // ****************************************************************
  localparam logic [7:0] sleep_control_addr = 8'h00;
  localparam logic [7:0] mcu_control_addr = 8'h04;
  localparam logic [7:0] status_addr = 8'h08;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int sleep_arm_bit = 0;
  localparam int sleep_select_lsb = 1;
  localparam int sleep_off_enable_bit = 5;
  localparam int brownout_sleep_off_bit = 6;
  localparam logic [7:0] sleep_control_reset = 8'h00;
  localparam logic [7:0] mcu_control_reset = 8'h00;

  // ****************************************************************
  // Mode codes.
  // ****************************************************************
  localparam logic [2:0] mode_idle = 3'h0;
  localparam logic [2:0] mode_noise = 3'h1;
  localparam logic [2:0] mode_power_down = 3'h2;
  localparam logic [2:0] mode_power_save = 3'h3;
  localparam logic [2:0] mode_standby = 3'h6;
  localparam logic [2:0] mode_ext_standby = 3'h7;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int clk_mhz = 25;
  localparam int halt_cycles = 4;
  localparam int standby_wake_cycles = 6;
  localparam int seq_window_cycles = 4;
  localparam int brownout_wake_us = 60;
  localparam int brownout_wake_cycles = brownout_wake_us * clk_mhz;

  // Controller states.
  typedef enum logic [2:0] {
    st_run,
    st_sleep,
    st_startup,
    st_halt
  } state_t;

endpackage
